// File: core/pfc_cfg.svh
// Constants of the program flow controller: vectors, register offsets, field positions.
// Included by pfc_core and the test bench; holds definitions only.
`ifndef PFC_CFG_SVH
`define PFC_CFG_SVH
`define PFC_RESET_VEC  13'h0000
`define PFC_IRQ_VEC    13'h0004
`define PFC_STK_FULL   4'h8
`define PFC_PCL_MADDR  4'hF
`define PFC_PCL_OFS    12'h000
`define PFC_STAT_OFS   12'h004
`define PFC_CTRL_OFS   12'h008
`define PFC_ACC_OFS    12'h00C
`define PFC_ST_C       0
`define PFC_ST_Z       1
`define PFC_ST_AC      2
`define PFC_ST_OV      3
`define PFC_ST_IRQ     4
`define PFC_ST_ISR     5
`define PFC_CTRL_IEN   0
`endif

// File: core/pfc_core.sv
// Program flow controller: four-phase cycle, fetch/execute pipeline, program
// counter, return stack and 8-bit ALU, with an APB register slave.
// Assumes a program memory that returns instr_data for instr_addr in the same cycle.
//
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pfc_cfg.svh"

module pfc_core (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Program memory
   output logic      [12:0] instr_addr,
   output logic             instr_fetch,
   input  wire logic [15:0] instr_data,
   // Interrupt and phase
   input  wire logic        irq_req,
   output logic             irq_ack,
   output logic      [3:0]  phase_out
);
   pfc_pkg::pfc_phase_e phase;
   pfc_pkg::pfc_op_e    op;
   logic [12:0] pc, fetch_pc, next_pc, stk_top;
   logic [15:0] exec_ir, fetch_ir;
   logic        exec_ok, fetch_ok, ext_wait, seen;
   logic [7:0]  acc, alu_res, b_op, bb, pcl_val, daa_adj;
   logic        c_f, z_f, ac_f, ov_f, n_c, n_ac, n_ov, upd_z;
   logic        wr_res, to_mem, skip_on, cin, sub_op;
   logic [8:0]  sum9, daa9;
   logic [4:0]  low5;
   logic [7:0]  dmem [0:15];
   logic [12:0] stk [0:7];
   logic [2:0]  stk_wp;
   logic [3:0]  stk_cnt, maddr;
   logic        irq_flag, in_isr, irq_en, pcl_pend;
   logic        at_t1, at_t4, is_br, is_ext, do_exec, do_alu, ext_start;
   logic        take_br, take_call, take_exit, take_skip, take_pclw;
   logic        redir, apb_go, irq_go, flush;
   logic        setup, access, hit, ro, bad;
   logic [31:0] rd_val;

   assign at_t1       = (phase == pfc_pkg::PH_T1);
   assign at_t4       = (phase == pfc_pkg::PH_T4);
   assign phase_out   = phase;
   assign instr_addr  = pc;
   assign instr_fetch = at_t1 & ~ext_wait;

   // Phase sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase <= pfc_pkg::PH_T1;
      end else begin
         case (phase)
            pfc_pkg::PH_T1: phase <= pfc_pkg::PH_T2;
            pfc_pkg::PH_T2: phase <= pfc_pkg::PH_T3;
            pfc_pkg::PH_T3: phase <= pfc_pkg::PH_T4;
            default:        phase <= pfc_pkg::PH_T1;
         endcase
      end
   end

   // Instruction decode
   assign op        = pfc_pkg::pfc_op_e'(exec_ir[13:9]);
   assign maddr     = exec_ir[3:0];
   assign is_br     = exec_ir[15] & exec_ir[14];
   assign is_ext    = exec_ir[15] & ~exec_ir[14];
   assign do_exec   = at_t4 & exec_ok & (~is_ext | ext_wait);
   assign ext_start = at_t4 & exec_ok & is_ext & ~ext_wait;
   assign do_alu    = do_exec & ~is_br;
   assign b_op      = (maddr == `PFC_PCL_MADDR) ? pc[7:0] : dmem[maddr];

   // ALU datapath
   assign sub_op  = (op == pfc_pkg::OP_SUB) | (op == pfc_pkg::OP_SBC);
   assign bb      = sub_op ? ~b_op : b_op;
   assign cin     = (op == pfc_pkg::OP_ADD) ? 1'b0 : (op == pfc_pkg::OP_SUB) ? 1'b1 : c_f;
   assign sum9    = {1'b0, acc} + {1'b0, bb} + {8'h00, cin};
   assign low5    = {1'b0, acc[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};
   assign daa_adj = {((acc[7:4] > 4'h9) | c_f) ? 4'h6 : 4'h0, ((acc[3:0] > 4'h9) | ac_f) ? 4'h6 : 4'h0};
   assign daa9    = {1'b0, acc} + {1'b0, daa_adj};

   always_comb begin
      alu_res = b_op;
      n_c     = c_f;
      n_ac    = ac_f;
      n_ov    = ov_f;
      upd_z   = 1'b1;
      wr_res  = 1'b1;
      skip_on = 1'b0;
      to_mem  = exec_ir[8];
      case (op)
         pfc_pkg::OP_ADD, pfc_pkg::OP_ADC, pfc_pkg::OP_SUB, pfc_pkg::OP_SBC: begin
            alu_res = sum9[7:0];
            n_c     = sum9[8];
            n_ac    = low5[4];
            n_ov    = (acc[7] == bb[7]) && (sum9[7] != acc[7]);
         end
         pfc_pkg::OP_DAA: begin
            alu_res = daa9[7:0];
            n_c     = daa9[8] | c_f;
            upd_z   = 1'b0;
         end
         pfc_pkg::OP_AND: alu_res = acc & b_op;
         pfc_pkg::OP_OR:  alu_res = acc | b_op;
         pfc_pkg::OP_XOR: alu_res = acc ^ b_op;
         pfc_pkg::OP_CPL: alu_res = ~b_op;
         pfc_pkg::OP_RR: begin
            alu_res = {b_op[0], b_op[7:1]};
            upd_z   = 1'b0;
         end
         pfc_pkg::OP_RRC: begin
            alu_res = {c_f, b_op[7:1]};
            n_c     = b_op[0];
            upd_z   = 1'b0;
         end
         pfc_pkg::OP_RL: begin
            alu_res = {b_op[6:0], b_op[7]};
            upd_z   = 1'b0;
         end
         pfc_pkg::OP_RLC: begin
            alu_res = {b_op[6:0], c_f};
            n_c     = b_op[7];
            upd_z   = 1'b0;
         end
         pfc_pkg::OP_INC: alu_res = b_op + 8'h01;
         pfc_pkg::OP_DEC: alu_res = b_op - 8'h01;
         pfc_pkg::OP_SZ, pfc_pkg::OP_SNZ: begin
            skip_on = (b_op == 8'h00) ^ (op == pfc_pkg::OP_SNZ);
            wr_res  = 1'b0;
            upd_z   = 1'b0;
         end
         pfc_pkg::OP_SIZ, pfc_pkg::OP_SDZ: begin
            alu_res = (op == pfc_pkg::OP_SIZ) ? b_op + 8'h01 : b_op - 8'h01;
            skip_on = (alu_res == 8'h00);
            upd_z   = 1'b0;
         end
         pfc_pkg::OP_MOVA: begin
            alu_res = acc;
            to_mem  = 1'b1;
            upd_z   = 1'b0;
         end
         pfc_pkg::OP_MOVM: begin
            to_mem  = 1'b0;
            upd_z   = 1'b0;
         end
         pfc_pkg::OP_LDI: begin
            alu_res = exec_ir[7:0];
            to_mem  = 1'b0;
            upd_z   = 1'b0;
         end
         default: begin
            wr_res  = 1'b0;
            upd_z   = 1'b0;
         end
      endcase
   end

   // Flow decisions; instruction redirects outrank APB branch, which outranks interrupts
   assign take_br   = do_exec & is_br;
   assign take_call = take_br & exec_ir[13];
   assign take_exit = do_alu & ((op == pfc_pkg::OP_ROUTINE_EXIT) | (op == pfc_pkg::OP_ISR_EXIT));
   assign take_skip = do_alu & skip_on;
   assign take_pclw = do_alu & wr_res & to_mem & (maddr == `PFC_PCL_MADDR);
   assign redir     = take_br | take_exit | take_skip | take_pclw;
   assign apb_go    = at_t4 & pcl_pend & ~redir & ~ext_start;
   assign irq_go    = at_t4 & irq_flag & ~in_isr & fetch_ok & (stk_cnt != `PFC_STK_FULL)
                      & ~redir & ~ext_start & ~apb_go;
   assign flush     = redir | apb_go | irq_go;
   assign stk_top   = stk[stk_wp - 3'h1];

   always_comb begin
      if (take_br) begin
         next_pc = exec_ir[12:0];
      end else if (take_exit) begin
         next_pc = stk_top;
      end else if (take_pclw) begin
         next_pc = {pc[12:8], alu_res};
      end else if (apb_go) begin
         next_pc = {pc[12:8], pcl_val};
      end else if (irq_go) begin
         next_pc = `PFC_IRQ_VEC;
      end else begin
         next_pc = pc;
      end
   end

   // Pipeline: fetch at T1, redirect and flush at T4
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc       <= `PFC_RESET_VEC;
         fetch_pc <= 13'h0000;
         fetch_ir <= 16'h0000;
         fetch_ok <= 1'b0;
         exec_ir  <= 16'h0000;
         exec_ok  <= 1'b0;
         ext_wait <= 1'b0;
      end else begin
         if (at_t1 && !ext_wait) begin
            exec_ir  <= fetch_ir;
            exec_ok  <= fetch_ok;
            fetch_ir <= instr_data;
            fetch_ok <= 1'b1;
            fetch_pc <= pc;
            pc       <= pc + 13'h0001;
         end
         if (at_t4) begin
            ext_wait <= ext_start;
            if (flush) begin
               pc       <= next_pc;
               fetch_ok <= 1'b0;
            end
         end
      end
   end

   // Accumulator and status flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc  <= 8'h00;
         c_f  <= 1'b0;
         z_f  <= 1'b0;
         ac_f <= 1'b0;
         ov_f <= 1'b0;
      end else if (do_alu) begin
         if (wr_res && !to_mem) begin
            acc <= alu_res;
         end
         c_f  <= n_c;
         ac_f <= n_ac;
         ov_f <= n_ov;
         if (upd_z) begin
            z_f <= (alu_res == 8'h00);
         end
      end
   end

   // Working data memory
   always_ff @(posedge pclk) begin
      if (do_alu && wr_res && to_mem) begin
         dmem[maddr] <= alu_res;
      end
   end

   // Return stack: circular so an overflowing push drops the oldest entry
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stk_wp  <= 3'h0;
         stk_cnt <= 4'h0;
      end else if (take_call || irq_go) begin
         stk_wp <= stk_wp + 3'h1;
         if (stk_cnt != `PFC_STK_FULL) begin
            stk_cnt <= stk_cnt + 4'h1;
         end
      end else if (take_exit) begin
         stk_wp <= stk_wp - 3'h1;
         if (stk_cnt != 4'h0) begin
            stk_cnt <= stk_cnt - 4'h1;
         end
      end
   end

   always_ff @(posedge pclk) begin
      if (take_call || irq_go) begin
         stk[stk_wp] <= fetch_pc;
      end
   end

   // Interrupt request latch and service state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_flag <= 1'b0;
         in_isr   <= 1'b0;
         irq_ack  <= 1'b0;
      end else begin
         irq_ack <= irq_go;
         if (irq_req && irq_en) begin
            irq_flag <= 1'b1;
         end else if (irq_go) begin
            irq_flag <= 1'b0;
         end
         if (irq_go) begin
            in_isr <= 1'b1;
         end else if (take_exit && op == pfc_pkg::OP_ISR_EXIT) begin
            in_isr <= 1'b0;
         end
      end
   end

   // APB decode
   assign setup   = psel & ~penable;
   assign access  = psel & penable;
   assign pready  = 1'b1;
   assign bad     = ~hit | (pwrite & ro);
   assign pslverr = access & bad;

   always_comb begin
      rd_val = 32'h0000_0000;
      hit    = 1'b1;
      ro     = 1'b0;
      if (paddr == `PFC_PCL_OFS) begin
         rd_val[7:0] = pc[7:0];
      end else if (paddr == `PFC_STAT_OFS) begin
         ro                  = 1'b1;
         rd_val[`PFC_ST_C]   = c_f;
         rd_val[`PFC_ST_Z]   = z_f;
         rd_val[`PFC_ST_AC]  = ac_f;
         rd_val[`PFC_ST_OV]  = ov_f;
         rd_val[`PFC_ST_IRQ] = irq_flag;
         rd_val[`PFC_ST_ISR] = in_isr;
      end else if (paddr == `PFC_CTRL_OFS) begin
         rd_val[`PFC_CTRL_IEN] = irq_en;
      end else if (paddr == `PFC_ACC_OFS) begin
         ro          = 1'b1;
         rd_val[7:0] = acc;
      end else begin
         hit = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (setup && !pwrite) begin
         prdata <= rd_val;
      end
   end

   // Software writes; a new low-byte write wins over the pending one being applied
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pcl_val  <= 8'h00;
         pcl_pend <= 1'b0;
         irq_en   <= 1'b0;
      end else begin
         if (access && pwrite && !bad && paddr == `PFC_PCL_OFS) begin
            pcl_val  <= pwdata[7:0];
            pcl_pend <= 1'b1;
         end else if (apb_go) begin
            pcl_pend <= 1'b0;
         end
         if (access && pwrite && !bad && paddr == `PFC_CTRL_OFS) begin
            irq_en <= pwdata[`PFC_CTRL_IEN];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seen <= 1'b0;
      end else begin
         seen <= 1'b1;
      end
   end

   default clocking dcb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence seq_quad;
      phase == pfc_pkg::PH_T2 ##1 phase == pfc_pkg::PH_T3 ##1 phase == pfc_pkg::PH_T4 ##1 at_t1;
   endsequence
   sequence seq_dummy_next;
      !fetch_ok ##1 !exec_ok;
   endsequence

   chk_phase_order: assert property (at_t1 |=> seq_quad)
      else $error("phase order broken");
   chk_pc_step: assert property (at_t1 && !ext_wait |=> pc == $past(pc) + 13'h0001)
      else $error("pc did not advance at T1");
   chk_acc_t4: assert property (!$stable(acc) |-> $past(at_t4))
      else $error("accumulator changed outside T4");
   chk_fetch_overlap: assert property (at_t1 && !ext_wait |=> exec_ir == $past(fetch_ir) && fetch_ir == $past(instr_data))
      else $error("pipeline did not shift");
   chk_ext_two: assert property (ext_start |=> ext_wait [*4] ##1 !ext_wait)
      else $error("extended cycle length wrong");
   chk_branch_target: assert property (take_br |=> (pc == $past(exec_ir[12:0])) and seq_dummy_next)
      else $error("branch target or dummy missing");
   chk_skip_flush: assert property (take_skip |=> !fetch_ok && pc == $past(pc))
      else $error("skip did not discard prefetch");
   chk_pcl_page: assert property (apb_go |=> (pc == {$past(pc[12:8]), $past(pcl_val)}) and seq_dummy_next)
      else $error("low byte branch wrong");
   chk_push_grow: assert property ((take_call || irq_go) && stk_cnt != 4'h8 |=> stk_cnt == $past(stk_cnt) + 4'h1)
      else $error("push did not grow stack");
   chk_call_full: assert property (take_call && stk_cnt == 4'h8 |=> stk_cnt == 4'h8 && stk_wp == $past(stk_wp) + 3'h1)
      else $error("full call not performed");
   chk_irq_held: assert property (irq_flag && stk_cnt == 4'h8 && !take_exit |=> irq_flag && !irq_ack)
      else $error("interrupt taken on full stack");
   chk_exit_restore: assert property (take_exit |=> pc == $past(stk_top))
      else $error("return did not restore pc");
   chk_reset_state: assert property (!seen |-> pc == 13'h0000 && stk_cnt == 4'h0)
      else $error("reset state wrong");
   chk_irq_vector: assert property (irq_go |=> pc == 13'h0004 && irq_ack && in_isr && !fetch_ok)
      else $error("interrupt entry wrong");
endmodule
`default_nettype wire

// File: core/pfc_pkg.sv
// Types of the program flow controller: phase states and instruction operations.
// Assumes nothing of its surroundings.
package pfc_pkg;
   typedef enum logic [3:0] {
      PH_T1 = 4'b0001,
      PH_T2 = 4'b0010,
      PH_T3 = 4'b0100,
      PH_T4 = 4'b1000
   } pfc_phase_e;
   typedef enum logic [4:0] {
      OP_NOP = 5'h00, OP_ADD = 5'h01, OP_ADC = 5'h02, OP_SUB = 5'h03,
      OP_SBC = 5'h04, OP_DAA = 5'h05, OP_AND = 5'h06, OP_OR = 5'h07,
      OP_XOR = 5'h08, OP_CPL = 5'h09, OP_RR = 5'h0A, OP_RRC = 5'h0B,
      OP_RL = 5'h0C, OP_RLC = 5'h0D, OP_INC = 5'h0E, OP_DEC = 5'h0F,
      OP_SZ = 5'h10, OP_SNZ = 5'h11, OP_SIZ = 5'h12, OP_SDZ = 5'h13,
      OP_MOVA = 5'h14, OP_MOVM = 5'h15, OP_LDI = 5'h16,
      OP_ROUTINE_EXIT = 5'h17, OP_ISR_EXIT = 5'h18
   } pfc_op_e;
endpackage

// File: tb/pfc_prog_mem.sv
// Program memory model: 8K words of 16 bits with a combinational read.
// Assumes the bench fills mem directly while the core is still held in reset.
`timescale 1ns/1ps
`default_nettype none
module pfc_prog_mem (
   // Fetch side
   input  wire logic [12:0] instr_addr,
   input  wire logic        instr_fetch,
   output logic      [15:0] instr_data
);
   logic [15:0] mem [0:8191];
   initial begin
      for (int i = 0; i < 8192; i++) begin
         mem[i] = 16'h0000;
      end
   end
   // Outside a fetch the word is inverted so stale data cannot pass for a fetch
   assign instr_data = instr_fetch ? mem[instr_addr] : ~mem[instr_addr];
endmodule
`default_nettype wire

// File: tb/test_cpu_program_flow_control.sv
// Self-checking bench of the program flow controller: APB master, program, traces.
// Assumes pfc_core and the program memory model pfc_prog_mem.
`timescale 1ns/1ps
`default_nettype none
`include "pfc_cfg.svh"
module test_cpu_program_flow_control;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [12:0] instr_addr;
   logic        instr_fetch;
   logic [15:0] instr_data;
   logic        irq_req;
   logic        irq_ack;
   logic [3:0]  phase_out;
   logic [12:0] trace [0:31];
   int          ncyc;
   int          n_errors = 0;
   int          checked = 0;
   logic [31:0] rd;
   logic        err;
   logic        seen;

   always #4 pclk = ~pclk;

   pfc_core i_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .instr_addr(instr_addr), .instr_fetch(instr_fetch), .instr_data(instr_data),
      .irq_req(irq_req), .irq_ack(irq_ack), .phase_out(phase_out)
   );
   pfc_prog_mem i_mem (.instr_addr(instr_addr), .instr_fetch(instr_fetch), .instr_data(instr_data));

   // Address fetched in each instruction cycle, 1FFF where no fetch is taken
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ncyc <= 0;
      end else if (phase_out === 4'h1) begin
         if (ncyc < 32) begin
            trace[ncyc] <= (instr_fetch === 1'b1) ? instr_addr : 13'h1FFF;
         end
         ncyc <= ncyc + 1;
      end
   end

   task automatic test_done;
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t value %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cmp_bit(input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      bit done;
      done = 1'b0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (int i = 0; i < 16 && !done; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) begin
            done = 1'b1;
            rd = prdata;
            err = pslverr;
         end
      end
      psel <= 1'b0;
      penable <= 1'b0;
      if (!done) begin
         $display("[FAIL] %0t bus transfer not answered", $time);
         n_errors++;
         test_done;
      end
   endtask

   // Looks for an acknowledge pulse, or a fetch of address a, within bound clocks
   task automatic wait_ev(input bit ack, input logic [12:0] a, input int bound);
      seen = 1'b0;
      for (int i = 0; i < bound && !seen; i++) begin
         @(posedge pclk);
         if (ack) begin
            seen = (irq_ack === 1'b1);
         end else begin
            seen = (instr_fetch === 1'b1 && instr_addr === a);
         end
      end
   endtask

   task automatic pulse_irq;
      @(posedge pclk);
      irq_req <= 1'b1;
      @(posedge pclk);
      irq_req <= 1'b0;
   endtask

   task automatic t_reset;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      #1;
      cmp_word({19'h0, instr_addr}, 32'h0000_0000);
      for (int i = 0; i < 4; i++) begin
         cmp_word({28'h0, phase_out}, 32'h1 << i);
         @(posedge pclk);
         #1;
      end
   endtask

   task automatic t_trace;
      logic [12:0] e [0:17];
      e = '{13'h000, 13'h001, 13'h010, 13'h011, 13'h012, 13'h013, 13'h014, 13'h015, 13'h020,
            13'h021, 13'h015, 13'h016, 13'h017, 13'h018, 13'h1FFF, 13'h019, 13'h108, 13'h109};
      for (int i = 0; i < 400 && ncyc < 18; i++) begin
         @(posedge pclk);
      end
      for (int i = 0; i < 18; i++) begin
         cmp_word({19'h0, trace[i]}, {19'h0, e[i]});
      end
   endtask

   task automatic t_regs;
      apb(1'b0, `PFC_ACC_OFS, 32'h0);
      cmp_word(rd, 32'h0000_000C);
      apb(1'b0, `PFC_STAT_OFS, 32'h0);
      cmp_bit(rd[`PFC_ST_C], 1'b1);
      apb(1'b0, `PFC_CTRL_OFS, 32'h0);
      cmp_word(rd, 32'h0000_0000);
      apb(1'b0, 12'h010, 32'h0);
      cmp_bit(err, 1'b1);
      cmp_word(rd, 32'h0000_0000);
      apb(1'b0, 12'h002, 32'h0);
      cmp_bit(err, 1'b1);
      apb(1'b1, `PFC_ACC_OFS, 32'h0000_0055);
      cmp_bit(err, 1'b1);
      apb(1'b0, `PFC_ACC_OFS, 32'h0);
      cmp_word(rd, 32'h0000_000C);
      apb(1'b0, `PFC_PCL_OFS, 32'h0);
      cmp_word({1'b0, rd[31:1]}, 32'h0000_0004);
   endtask

   task automatic t_pcl;
      apb(1'b1, `PFC_PCL_OFS, 32'h0000_0040);
      wait_ev(1'b0, 13'h140, 60);
      cmp_bit(seen, 1'b1);
      apb(1'b0, `PFC_PCL_OFS, 32'h0);
      cmp_word({1'b0, rd[31:1]}, 32'h0000_0020);
   endtask

   task automatic t_irq;
      pulse_irq;
      wait_ev(1'b1, 13'h0, 40);
      cmp_bit(seen, 1'b0);
      apb(1'b1, `PFC_CTRL_OFS, 32'h0000_0001);
      pulse_irq;
      wait_ev(1'b1, 13'h0, 40);
      cmp_bit(seen, 1'b1);
      // The vector fetch stands in the same cycle as the acknowledge pulse
      cmp_word({19'h0, instr_addr}, {19'h0, `PFC_IRQ_VEC});
      cmp_bit(instr_fetch, 1'b1);
      wait_ev(1'b0, 13'h140, 40);
      cmp_bit(seen, 1'b1);
      apb(1'b0, `PFC_STAT_OFS, 32'h0);
      cmp_word({30'h0, rd[`PFC_ST_ISR:`PFC_ST_IRQ]}, 32'h0);
   endtask

   task automatic t_stack;
      apb(1'b1, `PFC_PCL_OFS, 32'h0000_0060);
      wait_ev(1'b0, 13'h169, 200);
      cmp_bit(seen, 1'b1);
      pulse_irq;
      wait_ev(1'b1, 13'h0, 60);
      cmp_bit(seen, 1'b0);
      apb(1'b0, `PFC_STAT_OFS, 32'h0);
      cmp_bit(rd[`PFC_ST_IRQ], 1'b1);
      apb(1'b1, `PFC_PCL_OFS, 32'h0000_0070);
      wait_ev(1'b1, 13'h0, 100);
      cmp_bit(seen, 1'b1);
      wait_ev(1'b0, 13'h169, 60);
      cmp_bit(seen, 1'b1);
   endtask

   // Subtract then decimal adjust: 15 - 3C = D9 with borrow, adjusted to 39 with carry
   task automatic t_alu;
      apb(1'b1, `PFC_PCL_OFS, 32'h0000_0080);
      wait_ev(1'b0, 13'h184, 100);
      cmp_bit(seen, 1'b1);
      apb(1'b0, `PFC_ACC_OFS, 32'h0);
      cmp_word(rd, 32'h0000_0039);
      apb(1'b0, `PFC_STAT_OFS, 32'h0);
      cmp_word({30'h0, rd[`PFC_ST_Z:`PFC_ST_C]}, 32'h0000_0001);
   endtask

   initial begin
      repeat (20000) @(posedge pclk);
      $display("[FAIL] %0t watchdog expired", $time);
      n_errors++;
      test_done;
   end

   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      irq_req = 1'b0;
      #1;
      i_mem.mem[13'h000] = 16'hC010;
      i_mem.mem[13'h004] = 16'h3000;
      i_mem.mem[13'h010] = 16'h2C3C;
      i_mem.mem[13'h011] = 16'h2901;
      i_mem.mem[13'h012] = 16'h2CD0;
      i_mem.mem[13'h013] = 16'h0201;
      i_mem.mem[13'h014] = 16'hE020;
      i_mem.mem[13'h015] = 16'h2201;
      i_mem.mem[13'h017] = 16'h8000;
      i_mem.mem[13'h018] = 16'hC108;
      i_mem.mem[13'h020] = 16'h2E00;
      i_mem.mem[13'h108] = 16'hC108;
      i_mem.mem[13'h140] = 16'hC140;
      for (int i = 0; i < 9; i++) begin
         i_mem.mem[13'h160 + i] = 16'hE161 + i[15:0];
      end
      i_mem.mem[13'h169] = 16'hC169;
      i_mem.mem[13'h170] = 16'h2E00;
      i_mem.mem[13'h180] = 16'h2C15;
      i_mem.mem[13'h181] = 16'h0601;
      i_mem.mem[13'h182] = 16'h0A00;
      i_mem.mem[13'h183] = 16'hC183;
      t_reset;
      t_trace;
      t_regs;
      t_pcl;
      t_irq;
      t_stack;
      t_alu;
      test_done;
   end
endmodule
`default_nettype wire
